// *** color_palette_lookup.sv ***
// Purpose: 256-entry color lookup with byte-wide host access
// Assumes: host strobes are synchronous to CLK, one per cycle at most
// Notes:   table contents are not reset; control registers are
//
// Functional notes
// - 256 entries, red green blue, translate pixels
// - masked-off pixel bits forced to zero in table lookups
// - one byte data port, three writes per entry in RGB, four in RBG
// - holding register filled before table update
// - orders RGB or RBG plus dummy slot
// - write start entry to low index only
// - sequence advances after each data write
// - RGB: third write commits, sequence restarts
// - RBG: fourth write commits, its data dropped
// - prefetch write loads holding, bumps index
// - data reads step fields, last reloads next
// - direct color 5/6/5 onto DAC high bits
// - stored fields are byte's six high bits
// - pixel words never split per byte here
`timescale 1ns/100ps
module color_palette_lookup
(
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic [7:0]  REG_INDEX,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	input  wire logic        DIRECT_COLOR,
	input  wire logic [15:0] PIX_DATA,
	input  wire logic        PIX_VALID,
	output logic             PIX_READY,
	output logic      [5:0]  DAC_RED,
	output logic      [5:0]  DAC_GREEN,
	output logic      [5:0]  DAC_BLUE,
	output logic             DAC_VALID,
	input  wire logic        DAC_READY
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	localparam int FW = palette_pkg::FIELD_W;

	logic [3*FW-1:0] table_mem [0:palette_pkg::TABLE_DEPTH-1]; // r,g,b
	logic [7:0]  border_color;   // stored and read back only; no bit of it reaches the pixel path
	logic [7:0]  index_low;      // shared entry index
	logic [7:0]  index_high;     // upper index, unused by the table
	logic [7:0]  pixel_mask;     // zero bits clear pixel bits
	logic [7:0]  cursor_holding; // cursor image holding byte
	logic        seq_order;      // 0: rgb, 1: rbg plus dummy
	logic [1:0]  seq_pos;        // current slot of the sequence
	logic [FW-1:0] hold_red;     // holding register fields
	logic [FW-1:0] hold_green;
	logic [FW-1:0] hold_blue;

	logic        wr_data;        // host write to the data port
	logic        rd_data;        // host read of the data port
	logic        seq_last;       // slot after which the entry ends
	palette_pkg::field_e sel;    // field picked by the sequence
	logic [FW-1:0] next_red;     // holding merged with this write
	logic [FW-1:0] next_green;
	logic [FW-1:0] next_blue;
	logic [7:0]  next_index;     // index after one step
	logic [3*FW-1:0] host_entry; // entry at index_low; prefetch and reload read the table directly

	logic [15:0] fifo_data;      // pixel leaving the buffer
	logic        fifo_valid;
	logic        take;           // pixel moves into the output stage
	logic [7:0]  masked_pixel;   // table address after masking
	logic [3*FW-1:0] pixel_entry;

	// ------------------------------------------------------------
	// host decode and sequence slot mapping
	// ------------------------------------------------------------
	// the data port carries one byte, one field, per write
	assign wr_data    = REG_WR && (REG_INDEX == palette_pkg::IDX_COLOR_DATA);
	assign rd_data    = REG_RD && !REG_WR &&
		(REG_INDEX == palette_pkg::IDX_COLOR_DATA);
	assign next_index = index_low + 8'h01;
	assign host_entry = table_mem[index_low];

	// slot to field: rgb runs 0..2, rbg adds a dummy slot 3
	always_comb
	begin
		case ({seq_order, seq_pos})
			3'h0:    sel = palette_pkg::FLD_RED;
			3'h1:    sel = palette_pkg::FLD_GREEN;
			3'h2:    sel = palette_pkg::FLD_BLUE;
			3'h4:    sel = palette_pkg::FLD_RED;
			3'h5:    sel = palette_pkg::FLD_BLUE;
			3'h6:    sel = palette_pkg::FLD_GREEN;
			default: sel = palette_pkg::FLD_NONE;
		endcase
	end

	// rgb ends on the third slot, rbg on the dummy
	assign seq_last = seq_order ? (seq_pos == palette_pkg::POS_DUMMY)
		: (seq_pos == palette_pkg::POS_THIRD);

	// a data write lands in the selected field; the dummy slot keeps
	// all three as they are, which drops that byte
	always_comb
	begin
		next_red   = hold_red;
		next_green = hold_green;
		next_blue  = hold_blue;
		if (sel == palette_pkg::FLD_RED)
			next_red = REG_WDATA[7:8-FW];
		else if (sel == palette_pkg::FLD_GREEN)
			next_green = REG_WDATA[7:8-FW];
		else if (sel == palette_pkg::FLD_BLUE)
			next_blue = REG_WDATA[7:8-FW];
	end

	// ------------------------------------------------------------
	// color table storage
	// ------------------------------------------------------------
	// no reset on the table: software loads every entry it uses
	always_ff @(posedge CLK)
	begin
		if (wr_data && seq_last)
			table_mem[index_low] <= {next_red, next_green, next_blue};
	end

	// ------------------------------------------------------------
	// plain host registers
	// ------------------------------------------------------------
	// border, mask, index high and cursor byte just store
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			border_color   <= palette_pkg::RESET_BYTE;
			index_high     <= palette_pkg::RESET_BYTE;
			pixel_mask     <= palette_pkg::RESET_MASK;
			cursor_holding <= palette_pkg::RESET_BYTE;
		end
		else if (REG_WR)
		begin
			case (REG_INDEX)
				palette_pkg::IDX_BORDER_COLOR:
					border_color <= REG_WDATA;
				palette_pkg::IDX_SHARED_INDEX_HIGH,
				palette_pkg::IDX_PREFETCH_HIGH:
					index_high <= REG_WDATA; // table ignores it
				palette_pkg::IDX_PIXEL_MASK:
					pixel_mask <= REG_WDATA;
				palette_pkg::IDX_CURSOR_HOLDING:
					cursor_holding <= REG_WDATA;
				default:
					border_color <= border_color;
			endcase
		end
	end

	// ------------------------------------------------------------
	// entry index
	// ------------------------------------------------------------
	// plain low index loads only; the prefetch index loads then
	// steps; commits and last-field reads step as well
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			index_low <= palette_pkg::RESET_BYTE;
		else if (REG_WR && REG_INDEX == palette_pkg::IDX_SHARED_INDEX_LOW)
			index_low <= REG_WDATA;
		else if (REG_WR && REG_INDEX == palette_pkg::IDX_PREFETCH_LOW)
			index_low <= REG_WDATA + 8'h01;
		else if (wr_data && seq_last)
			index_low <= next_index; // ready for the next entry
		else if (rd_data && seq_last)
			index_low <= next_index;
	end

	// ------------------------------------------------------------
	// field sequence
	// ------------------------------------------------------------
	// writes to the sequence register pick the order and load the slot from bits 1:0
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			seq_order <= 1'b0;
			seq_pos   <= palette_pkg::POS_FIRST;
		end
		else if (REG_WR && REG_INDEX == palette_pkg::IDX_FIELD_SEQUENCE)
		begin
			seq_order <= REG_WDATA[palette_pkg::SEQ_ORDER_BIT];
			seq_pos   <= REG_WDATA[1:0];
		end
		else if ((wr_data || rd_data) && seq_last)
			seq_pos <= palette_pkg::POS_FIRST;
		else if (wr_data || rd_data)
			seq_pos <= seq_pos + 2'h1;
	end

	// ------------------------------------------------------------
	// holding register
	// ------------------------------------------------------------
	// filled by data writes, direct writes, prefetch and reload
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			hold_red   <= '0;
			hold_green <= '0;
			hold_blue  <= '0;
		end
		else if (REG_WR && REG_INDEX == palette_pkg::IDX_PREFETCH_LOW)
		begin
			// entry named by the written index, before the step
			{hold_red, hold_green, hold_blue} <=
				table_mem[REG_WDATA];
		end
		else if (wr_data)
		begin
			hold_red   <= next_red;
			hold_green <= next_green;
			hold_blue  <= next_blue;
		end
		else if (rd_data && seq_last)
			{hold_red, hold_green, hold_blue} <=
				table_mem[next_index];
		else if (REG_WR && REG_INDEX == palette_pkg::IDX_RED_HOLDING)
			hold_red <= REG_WDATA[7:8-FW];
		else if (REG_WR && REG_INDEX == palette_pkg::IDX_GREEN_HOLDING)
			hold_green <= REG_WDATA[7:8-FW];
		else if (REG_WR && REG_INDEX == palette_pkg::IDX_BLUE_HOLDING)
			hold_blue <= REG_WDATA[7:8-FW];
	end

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// registered: data appears the cycle after the read strobe;
	// unmapped indices and the dummy slot read as zero
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			REG_RDATA <= palette_pkg::RESET_BYTE;
		else if (REG_RD)
		begin
			case (REG_INDEX)
				palette_pkg::IDX_BORDER_COLOR:
					REG_RDATA <= border_color;
				palette_pkg::IDX_SHARED_INDEX_LOW,
				palette_pkg::IDX_PREFETCH_LOW:
					REG_RDATA <= index_low;
				palette_pkg::IDX_SHARED_INDEX_HIGH,
				palette_pkg::IDX_PREFETCH_HIGH:
					REG_RDATA <= index_high;
				palette_pkg::IDX_PIXEL_MASK:
					REG_RDATA <= pixel_mask;
				palette_pkg::IDX_COLOR_DATA:
					case (sel)
						palette_pkg::FLD_RED:   REG_RDATA <= {hold_red, 2'h0};
						palette_pkg::FLD_GREEN: REG_RDATA <= {hold_green, 2'h0};
						palette_pkg::FLD_BLUE:  REG_RDATA <= {hold_blue, 2'h0};
						default:                REG_RDATA <= 8'h00;
					endcase
				palette_pkg::IDX_FIELD_SEQUENCE:
					REG_RDATA <= {5'h00, seq_order, seq_pos};
				palette_pkg::IDX_RED_HOLDING:
					REG_RDATA <= {hold_red, 2'h0};
				palette_pkg::IDX_GREEN_HOLDING:
					REG_RDATA <= {hold_green, 2'h0};
				palette_pkg::IDX_BLUE_HOLDING:
					REG_RDATA <= {hold_blue, 2'h0};
				palette_pkg::IDX_CURSOR_HOLDING:
					REG_RDATA <= cursor_holding;
				default:
					REG_RDATA <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pixel path
	// ------------------------------------------------------------
	// the buffer absorbs bursts while the DACs stall
	pixel_fifo
	#(
		.WIDTH (palette_pkg::PIXEL_W),
		.DEPTH (palette_pkg::FIFO_DEPTH)
	)
	u_pixel_fifo
	(
		.CLK       (CLK),
		.ARST_N    (ARST_N),
		.IN_DATA   (PIX_DATA),
		.IN_VALID  (PIX_VALID),
		.IN_READY  (PIX_READY),
		.OUT_DATA  (fifo_data),
		.OUT_VALID (fifo_valid),
		.OUT_READY (take)
	);

	// the lookup has its own read port, so host traffic never
	// steals a cycle from the display
	assign take         = fifo_valid && (!DAC_VALID || DAC_READY);
	assign masked_pixel = fifo_data[7:0] & pixel_mask;
	assign pixel_entry  = table_mem[masked_pixel];

	// one output stage: a pixel taken shows on the next edge;
	// a 16-bit pixel gives one color, never one per byte; a lookup uses its low byte only
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			DAC_VALID <= 1'b0;
			DAC_RED   <= '0;
			DAC_GREEN <= '0;
			DAC_BLUE  <= '0;
		end
		else if (take)
		begin
			DAC_VALID <= 1'b1;
			if (DIRECT_COLOR)
			begin
				DAC_RED   <= {fifo_data[15:11], 1'b0};
				DAC_GREEN <= fifo_data[10:5];
				DAC_BLUE  <= {fifo_data[4:0], 1'b0};
			end
			else
				{DAC_RED, DAC_GREEN, DAC_BLUE} <= pixel_entry;
		end
		else if (DAC_READY)
			DAC_VALID <= 1'b0;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!ARST_N);

	AST_MASK_ZERO:
		assert property (take && !DIRECT_COLOR && pixel_mask == 8'h00
			|=> {DAC_RED, DAC_GREEN, DAC_BLUE} == $past(table_mem[0]))
		else $error("masked pixel did not address entry zero");

	AST_DIRECT_MAP:
		assert property (take && DIRECT_COLOR
			|=> DAC_RED[5:1] == $past(fifo_data[15:11])
			&& DAC_GREEN == $past(fifo_data[10:5])
			&& DAC_BLUE[5:1] == $past(fifo_data[4:0]))
		else $error("direct color fields misplaced");

	AST_RGB_COMMIT:
		assert property (wr_data && !seq_order
			&& seq_pos == palette_pkg::POS_THIRD
			|=> seq_pos == palette_pkg::POS_FIRST
			&& index_low == $past(index_low) + 8'h01)
		else $error("third rgb write did not commit");

	AST_RBG_WAIT:
		assert property (wr_data && seq_order
			&& seq_pos == palette_pkg::POS_THIRD
			|=> index_low == $past(index_low)
			&& seq_pos == palette_pkg::POS_DUMMY)
		else $error("rbg sequence committed before dummy write");

	AST_SEQ_STEP:
		assert property (wr_data && !seq_last
			|=> seq_pos == $past(seq_pos) + 2'h1)
		else $error("sequence did not advance on data write");

	AST_PREFETCH:
		assert property (REG_WR && REG_INDEX == palette_pkg::IDX_PREFETCH_LOW
			|=> index_low == $past(REG_WDATA) + 8'h01
			&& {hold_red, hold_green, hold_blue}
			== $past(table_mem[REG_WDATA]))
		else $error("prefetch did not load and step");

	AST_READ_STEP:
		assert property (rd_data && !seq_last
			|=> seq_pos == $past(seq_pos) + 2'h1
			&& index_low == $past(index_low))
		else $error("data read did not step the sequence");

	AST_DAC_HOLD:
		assert property (DAC_VALID && !DAC_READY
			|=> DAC_VALID && $stable(DAC_RED) && $stable(DAC_GREEN)
			&& $stable(DAC_BLUE))
		else $error("output changed while stalled");

	COV_RGB_LOAD:
		cover property (wr_data && !seq_order && seq_last);
	COV_RBG_LOAD:
		cover property (wr_data && seq_order && seq_last);
	COV_READ_RELOAD:
		cover property (rd_data && seq_last);
	COV_FIFO_FULL:
		cover property (PIX_VALID && !PIX_READY);
endmodule

// *** dac_sink_model.sv ***
// Purpose: video output consumer for the lookup stage
// Assumes: colors are taken when valid and ready meet at an edge
// Notes:   stall holds ready low to back the pipeline up
`timescale 1ns/100ps
module dac_sink_model
(
	input  wire logic       CLK,
	input  wire logic       ARST_N,
	input  wire logic [5:0] DAC_RED,
	input  wire logic [5:0] DAC_GREEN,
	input  wire logic [5:0] DAC_BLUE,
	input  wire logic       DAC_VALID,
	input  wire logic       STALL,
	output logic            DAC_READY
);
	// ----------------------------------------------------------
	// capture
	// ----------------------------------------------------------
	logic [17:0] got[$];    // colors in arrival order

	initial DAC_READY = 1'b0;

	// ready moves just after the edge, like a real consumer
	always @(posedge CLK)
	begin
		#1;
		DAC_READY = ARST_N && !STALL;
	end

	// record each accepted color, in order
	always @(posedge CLK)
	begin
		if (ARST_N && DAC_VALID === 1'b1 && DAC_READY)
			got.push_back({DAC_RED, DAC_GREEN, DAC_BLUE});
	end
endmodule

// *** palette_pkg.sv ***
// Purpose: shared constants for the color lookup stage
// Assumes: byte-wide indexed host registers, 6-bit color fields
// Notes:   register indices are eight bits wide
package palette_pkg;
	// ------------------------------------------------------------
	// register indices
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_BORDER_COLOR      = 8'h55;
	localparam logic [7:0] IDX_SHARED_INDEX_LOW  = 8'h60;
	localparam logic [7:0] IDX_SHARED_INDEX_HIGH = 8'h61;
	localparam logic [7:0] IDX_PREFETCH_LOW      = 8'h62;
	localparam logic [7:0] IDX_PREFETCH_HIGH     = 8'h63;
	localparam logic [7:0] IDX_PIXEL_MASK        = 8'h64;
	localparam logic [7:0] IDX_COLOR_DATA        = 8'h65;
	localparam logic [7:0] IDX_FIELD_SEQUENCE    = 8'h66;
	localparam logic [7:0] IDX_RED_HOLDING       = 8'h67;
	localparam logic [7:0] IDX_GREEN_HOLDING     = 8'h68;
	localparam logic [7:0] IDX_BLUE_HOLDING      = 8'h69;
	localparam logic [7:0] IDX_CURSOR_HOLDING    = 8'h6b;

	// ------------------------------------------------------------
	// sizes, fields and reset values
	// ------------------------------------------------------------
	localparam int TABLE_DEPTH  = 256;  // entries in the color table
	localparam int FIELD_W      = 6;    // stored bits per color field
	localparam int PIXEL_W      = 16;   // widest pixel (direct color)
	localparam int FIFO_DEPTH   = 32;   // pixel buffer words
	localparam int SEQ_ORDER_BIT = 2;   // sequence register: order select
	localparam int BORDER_HALF_BIT = 7; // border color: half select bit, unused; border never reaches the table
	localparam logic [7:0] RESET_MASK = 8'hff;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] POS_FIRST  = 2'h0;
	localparam logic [1:0] POS_THIRD  = 2'h2;
	localparam logic [1:0] POS_DUMMY  = 2'h3;

	// color field selected by the sequence position
	typedef enum logic [1:0]
	{
		FLD_RED   = 2'h0,
		FLD_GREEN = 2'h1,
		FLD_BLUE  = 2'h2,
		FLD_NONE  = 2'h3
	} field_e;
endpackage

// *** pixel_fifo.sv ***
// Purpose: pixel buffer between the pixel source and the lookup stage
// Assumes: one clock, write and read may happen in the same cycle
// Notes:   full and empty come from a count one wider than the pointers
`timescale 1ns/100ps
module pixel_fifo
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
)
(
	input  wire logic             CLK,
	input  wire logic             ARST_N,
	input  wire logic [WIDTH-1:0] IN_DATA,
	input  wire logic             IN_VALID,
	output logic                  IN_READY,
	output logic      [WIDTH-1:0] OUT_DATA,
	output logic                  OUT_VALID,
	input  wire logic             OUT_READY
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [0:DEPTH-1]; // buffer words
	logic [AW-1:0]    wr_ptr;            // next slot to fill
	logic [AW-1:0]    rd_ptr;            // oldest word
	logic [AW:0]      count;             // words held
	logic             push;
	logic             pop;

	// handshakes are combinational so back-pressure reaches the source
	assign IN_READY  = (count != DEPTH[AW:0]);
	assign OUT_VALID = (count != '0);
	assign OUT_DATA  = store[rd_ptr];
	assign push      = IN_VALID && IN_READY;
	assign pop       = OUT_VALID && OUT_READY;

	// storage has no reset: contents are meaningless until counted
	always_ff @(posedge CLK)
	begin
		if (push)
			store[wr_ptr] <= IN_DATA;
	end

	// pointers and fill level
	always_ff @(posedge CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// *** testbench.sv ***
// Purpose: register and pixel-path checks of the color lookup stage
// Assumes: read data valid one cycle after the read strobe
// Notes:   table entries are only read after being written
`timescale 1ns/100ps
module testbench;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  reg_index = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        direct = 1'b0;
	logic [15:0] pix_data = 16'h0000;
	logic        pix_valid = 1'b0;
	logic        pix_ready;
	logic [5:0]  red, green, blue;
	logic        dac_valid, dac_ready;
	logic        stall = 1'b0;
	int          num_errors = 0;
	int          comparisons = 0;
	int          i, cnt;

	always #2.5 clk = ~clk;

	color_palette_lookup uut (.CLK(clk), .ARST_N(arst_n),
		.REG_INDEX(reg_index), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_RDATA(reg_rdata), .DIRECT_COLOR(direct),
		.PIX_DATA(pix_data), .PIX_VALID(pix_valid), .PIX_READY(pix_ready),
		.DAC_RED(red), .DAC_GREEN(green), .DAC_BLUE(blue),
		.DAC_VALID(dac_valid), .DAC_READY(dac_ready));

	dac_sink_model sink (.CLK(clk), .ARST_N(arst_n), .DAC_RED(red),
		.DAC_GREEN(green), .DAC_BLUE(blue), .DAC_VALID(dac_valid),
		.STALL(stall), .DAC_READY(dac_ready));

	// ----------------------------------------------------------
	// reporting
	// ----------------------------------------------------------
	task wrap_up;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk_byte(input string what, input logic [7:0] e,
		input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task chk_color(input string what, input logic [17:0] e,
		input logic [17:0] g);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	// a wait that ran out ends the run as a mismatch
	task timeout(input string what);
		num_errors++;
		$display("[FAIL] %s expected done seen timeout", what);
		wrap_up();
	endtask

	// ----------------------------------------------------------
	// register access, one idle cycle between strobes
	// ----------------------------------------------------------
	task reg_write(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_index = idx;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
	endtask

	task rd_chk(input logic [7:0] idx, input logic [7:0] e,
		input string what);
		@(posedge clk);
		#1;
		reg_index = idx;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		chk_byte(what, e, reg_rdata);
	endtask

	// ----------------------------------------------------------
	// pixel path
	// ----------------------------------------------------------
	function automatic logic [17:0] direct_rgb(input logic [15:0] p);
		return {p[15:11], 1'b0, p[10:5], p[4:0], 1'b0};
	endfunction

	task take_color(input logic [15:0] p, input logic [17:0] e,
		input string what);
		int n;
		@(posedge clk);
		#1;
		sink.got.delete();
		pix_data = p;
		pix_valid = 1'b1;
		for (n = 0; n < 50 && pix_ready !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		if (pix_ready !== 1'b1)
			timeout(what);
		@(posedge clk);
		#1;
		pix_valid = 1'b0;
		for (n = 0; n < 20 && sink.got.size() == 0; n++)
			@(posedge clk);
		if (sink.got.size() == 0)
			timeout(what);
		chk_color(what, e, sink.got[0]);
	endtask

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		#1;
		arst_n = 1'b1;
		// control registers after reset, unmapped index
		rd_chk(palette_pkg::IDX_PIXEL_MASK, palette_pkg::RESET_MASK, "mask");
		rd_chk(palette_pkg::IDX_FIELD_SEQUENCE, 8'h00, "seq reset");
		rd_chk(8'h70, 8'h00, "unmapped");
		reg_write(palette_pkg::IDX_BORDER_COLOR, 8'h80);
		rd_chk(palette_pkg::IDX_BORDER_COLOR, 8'h80, "border");
		// red green blue order; high index must not matter
		reg_write(palette_pkg::IDX_SHARED_INDEX_HIGH, 8'h05);
		reg_write(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h10);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'hff);
		rd_chk(palette_pkg::IDX_FIELD_SEQUENCE, 8'h01, "seq step");
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h80);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h47);
		rd_chk(palette_pkg::IDX_FIELD_SEQUENCE, 8'h00, "seq wrap");
		rd_chk(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h11, "index");
		// red blue green order with dummy slot, entry 20
		reg_write(palette_pkg::IDX_FIELD_SEQUENCE, 8'h04);
		reg_write(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h20);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h0b);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h0e);
		rd_chk(palette_pkg::IDX_FIELD_SEQUENCE, 8'h06, "rbg step");
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h04);
		rd_chk(palette_pkg::IDX_FIELD_SEQUENCE, 8'h07, "rbg dummy");
		rd_chk(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h20, "no commit");
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'hfc);
		rd_chk(palette_pkg::IDX_FIELD_SEQUENCE, 8'h04, "rbg wrap");
		rd_chk(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h21, "rbg index");
		// prefetch and read back entry 10
		reg_write(palette_pkg::IDX_FIELD_SEQUENCE, 8'h00);
		reg_write(palette_pkg::IDX_PREFETCH_LOW, 8'h10);
		rd_chk(palette_pkg::IDX_RED_HOLDING, 8'hfc, "hold red");
		rd_chk(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h11, "pf index");
		rd_chk(palette_pkg::IDX_COLOR_DATA, 8'hfc, "rd red");
		rd_chk(palette_pkg::IDX_COLOR_DATA, 8'h80, "rd green");
		rd_chk(palette_pkg::IDX_COLOR_DATA, 8'h44, "rd blue");
		rd_chk(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h12, "rd index");
		// shared state an interrupting task saves and restores
		reg_write(palette_pkg::IDX_GREEN_HOLDING, 8'h9c);
		reg_write(palette_pkg::IDX_CURSOR_HOLDING, 8'h5a);
		rd_chk(palette_pkg::IDX_GREEN_HOLDING, 8'h9c, "hold g");
		rd_chk(palette_pkg::IDX_CURSOR_HOLDING, 8'h5a, "cursor");
		rd_chk(palette_pkg::IDX_SHARED_INDEX_HIGH, 8'h05, "idx hi");
		// table lookup, then masked lookup
		take_color(16'h0010, {6'h3f, 6'h20, 6'h11}, "lookup");
		take_color(16'h0020, {6'h02, 6'h01, 6'h03}, "lookup rbg");
		reg_write(palette_pkg::IDX_PIXEL_MASK, 8'h1f);
		take_color(16'hff30, {6'h3f, 6'h20, 6'h11}, "masked");
		reg_write(palette_pkg::IDX_PIXEL_MASK, palette_pkg::RESET_MASK);
		// entry 0 pure green, entry 1 first blue ramp step
		reg_write(palette_pkg::IDX_SHARED_INDEX_LOW, 8'h00);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h00);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'ha8);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h00);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h00);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h00);
		reg_write(palette_pkg::IDX_COLOR_DATA, 8'h08);
		take_color(16'h0001, {6'h00, 6'h00, 6'h02}, "ramp");
		// a zero mask sends every pixel to entry 0
		reg_write(palette_pkg::IDX_PIXEL_MASK, 8'h00);
		take_color(16'h00ff, {6'h00, 6'h2a, 6'h00}, "mask zero");
		reg_write(palette_pkg::IDX_PIXEL_MASK, palette_pkg::RESET_MASK);
		// byte moves and map widths stay with the host side
		// direct color fields
		direct = 1'b1;
		take_color(16'hf81f, direct_rgb(16'hf81f), "direct rb");
		take_color(16'h07e0, {6'h00, 6'h3f, 6'h00}, "direct g");
		// fill with the consumer stalled; output reg holds one more
		stall = 1'b1;
		sink.got.delete();
		cnt = 0;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			#1;
			if (pix_ready !== 1'b1)
				break;
			pix_data = 16'(i * 16'h0843);
			pix_valid = 1'b1;
			cnt++;
		end
		pix_valid = 1'b0;
		chk_byte("accepted", 8'(palette_pkg::FIFO_DEPTH + 1), 8'(cnt));
		repeat (5) @(posedge clk);
		#1;
		chk_byte("refused", 8'h00, {7'h00, pix_ready});
		stall = 1'b0;
		for (i = 0; i < 200 && sink.got.size() < cnt; i++)
			@(posedge clk);
		if (sink.got.size() < cnt)
			timeout("drain");
		for (i = 0; i < cnt; i++)
			chk_color("drain", direct_rgb(16'(i * 16'h0843)), sink.got[i]);
		wrap_up();
	end
endmodule
